// ===== src/sccs_pkg.sv
/*
 * Shared constants of the storage card command block: register map, opcodes,
 * status bit positions, diagnostic codes, reset values and cycle counts.
 * Assumes a 20 MHz register clock (pclk).
 */
package sccs_pkg;

   // Register byte offsets on APB
   localparam logic [7:0] OFF_DATA     = 8'h00;
   localparam logic [7:0] OFF_ERROR    = 8'h04;
   localparam logic [7:0] OFF_SEC_CNT  = 8'h08;
   localparam logic [7:0] OFF_SEC_NUM  = 8'h0C;
   localparam logic [7:0] OFF_CYL_LO   = 8'h10;
   localparam logic [7:0] OFF_CYL_HI   = 8'h14;
   localparam logic [7:0] OFF_DRV_HEAD = 8'h18;
   localparam logic [7:0] OFF_CMD_STAT = 8'h1C;
   localparam logic [7:0] OFF_DEV_CTRL = 8'h20;
   localparam logic [7:0] OFF_CONFIG   = 8'h24;

   // Opcodes
   localparam logic [7:0] OP_PWR_QUERY_A = 8'h98;
   localparam logic [7:0] OP_PWR_QUERY_B = 8'hE5;
   localparam logic [7:0] OP_DIAG        = 8'h90;
   localparam logic [7:0] OP_ERASE       = 8'hC0;
   localparam logic [7:0] OP_IDENTIFY    = 8'hEC;

   // Status bit positions
   localparam int ST_BUSY = 7;
   localparam int ST_RDY  = 6;
   localparam int ST_DWF  = 5;
   localparam int ST_DSC  = 4;
   localparam int ST_DRQ  = 3;
   localparam int ST_ERR  = 0;

   // Field positions
   localparam int DH_DRV      = 4;
   localparam int DC_NIEN     = 1;
   localparam int DC_SRST     = 2;
   localparam int CF_EMU      = 0;
   localparam int CF_SECOND   = 1;
   localparam int CF_PWR_LO   = 2;
   localparam int CF_CODE_LO  = 4;

   // Power states in the config register
   localparam logic [1:0] PWR_IDLE = 2'h0;

   // Diagnostic and error codes
   localparam logic [7:0] DIAG_OK        = 8'h01;
   localparam logic [7:0] DIAG_SEC_FAIL  = 8'h80;
   localparam logic [7:0] ERR_ABORT      = 8'h04;
   localparam logic [7:0] PWR_CNT_IDLE   = 8'hFF;
   localparam logic [7:0] PWR_CNT_STBY   = 8'h00;

   // Reset values
   localparam logic [7:0] SEC_CNT_RST    = 8'h01;
   localparam logic [7:0] SEC_NUM_RST    = 8'h01;
   localparam logic [2:0] SELF_CODE_RST  = 3'h1;

   // Timing
   localparam int CLK_PERIOD_NS   = 50;
   localparam int BUSY_SET_MAX_NS = 400;
   localparam int BUSY_SET_MAX_CYC =
      (BUSY_SET_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : (BUSY_SET_MAX_NS / CLK_PERIOD_NS);
   localparam logic [7:0] EXEC_CYC = 8'h04;
   localparam int DIAG_CYC        = 16;
   localparam int IDENT_WORDS     = 256;

   typedef enum logic [2:0] {S_IDLE, S_EXEC, S_WAIT_DIAG, S_FINISH, S_XFER} sccs_state_t;

endpackage : sccs_pkg

// ===== src/sccs_ident_rom.sv
/*
 * Identify parameter block: 256 sixteen-bit words, registered read data.
 * Assumes the caller presents the next word index one cycle before use.
 */
`timescale 1ns/100ps
`default_nettype none
module sccs_ident_rom
   import sccs_pkg::*;
#(
   parameter logic [15:0] CYLINDERS   = 16'h03D0,
   parameter logic [15:0] HEADS       = 16'h0010,
   parameter logic [15:0] SPT         = 16'h0020,
   parameter logic [31:0] TOTAL_SECT  = 32'h0007A000,
   parameter logic [15:0] CFG_REMOV   = 16'h0080,   // Arbitrary value
   parameter logic [15:0] CFG_FIXED   = 16'h0040,   // Arbitrary value, bit 6 set
   parameter logic [63:0] SERIAL      = 64'h3030303030303031,
   parameter logic [63:0] FIRMWARE    = 64'h312E303020202020,
   parameter logic [63:0] MODEL       = 64'h464C415348435244,
   parameter logic [7:0]  MULT_MAX    = 8'h01
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  addr,
   input  wire logic        emu_mode,
   output logic [15:0]      q
);

   typedef struct packed {
      logic [15:0] q;
   } sccs_rom_s_t;

   sccs_rom_s_t s_q, s_d;

   function automatic logic [15:0] word_of(input logic [7:0] a, input logic emu);
      logic [15:0] w;
      w = 16'h0000;
      unique case (a)
         8'd0:  w = emu ? CFG_FIXED : CFG_REMOV;
         8'd1:  w = CYLINDERS;
         8'd3:  w = HEADS;
         8'd6:  w = SPT;
         8'd7:  w = TOTAL_SECT[31:16];
         8'd8:  w = TOTAL_SECT[15:0];
         8'd16: w = SERIAL[63:48];
         8'd17: w = SERIAL[47:32];
         8'd18: w = SERIAL[31:16];
         8'd19: w = SERIAL[15:0];
         8'd23: w = FIRMWARE[63:48];
         8'd24: w = FIRMWARE[47:32];
         8'd25: w = FIRMWARE[31:16];
         8'd26: w = FIRMWARE[15:0];
         8'd27: w = MODEL[63:48];
         8'd28: w = MODEL[47:32];
         8'd29: w = MODEL[31:16];
         8'd30: w = MODEL[15:0];
         8'd47: w = {8'h00, MULT_MAX};
         8'd49: w = 16'h0300;
         8'd51: w = 16'h0200;
         8'd53: w = 16'h0003;
         default:
         begin
            if ((a >= 8'd10 && a <= 8'd15) || (a >= 8'd31 && a <= 8'd46))
               w = 16'h2020;
         end
      endcase
      return w;
   endfunction : word_of

   always_comb
   begin
      s_d   = s_q;
      s_d.q = word_of(addr, emu_mode);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign q = s_q.q;

endmodule : sccs_ident_rom
`default_nettype wire

// ===== src/sccs_diag.sv
/*
 * Drive self test: runs a fixed number of cycles after start and returns a
 * result code, flagging a failed secondary drive in the upper nibble.
 * Assumes start is a one-cycle pulse from logic on pclk.
 */
`timescale 1ns/100ps
`default_nettype none
module sccs_diag
   import sccs_pkg::*;
#(
   parameter int CYCLES = DIAG_CYC
)(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic [2:0] self_code,
   input  wire logic       report_second,
   input  wire logic       second_fail,
   output logic            done,
   output logic [7:0]      code
);

   typedef struct packed {
      logic        run;
      logic [15:0] cnt;
      logic        done;
      logic [7:0]  code;
   } sccs_diag_s_t;

   sccs_diag_s_t s_q, s_d;

   always_comb
   begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (start)
      begin
         s_d.run = 1'b1;
         s_d.cnt = 16'(CYCLES - 1);
      end
      else if (s_q.run)
      begin
         if (s_q.cnt == 16'h0000)
         begin
            s_d.run  = 1'b0;
            s_d.done = 1'b1;
            s_d.code = {5'h00, self_code};
            if (report_second && second_fail)
               s_d.code = DIAG_SEC_FAIL | {5'h00, self_code};
         end
         else
            s_d.cnt = s_q.cnt - 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign done = s_q.done;
   assign code = s_q.code;

endmodule : sccs_diag
`default_nettype wire

// ===== src/sccs_cmd.sv
/*
 * Command interpreter of a flash storage card: task-file registers on APB,
 * power query, self test, sector erase and identify commands.
 * Assumes one pclk domain; the two fault pins come from outside and are
 * synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none

module sccs_cmd
   import sccs_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        second_fail_pin,
   input  wire logic        media_fault_pin,
   output logic             intrq,
   output logic             cmd_in_progress_flag
);

   typedef struct packed {
      sccs_state_t st;
      logic        busy;
      logic        drq;
      logic        err;
      logic        dwf;
      logic        irq;
      logic        nien;
      logic        srst;
      logic        emu;
      logic        second;
      logic [1:0]  pwr;
      logic [2:0]  self_code;
      logic [7:0]  err_reg;
      logic [7:0]  sec_cnt;
      logic [7:0]  sec_num;
      logic [7:0]  cyl_lo;
      logic [7:0]  cyl_hi;
      logic [7:0]  drv_head;
      logic [7:0]  cur_cmd;
      logic [7:0]  cnt;
      logic [8:0]  widx;
      logic [31:0] prdata;
      logic [1:0]  sfail_sync;
      logic [1:0]  mfault_sync;
   } sccs_cmd_s_t;

   sccs_cmd_s_t s_q, s_d;

   logic        setup;
   logic        access;
   logic        diag_start;
   logic        diag_done;
   logic [7:0]  diag_code;
   logic [15:0] rom_q;
   logic [7:0]  status;
   logic        data_rd;
   logic        stat_rd;
   logic        drv_match;
   logic        diag_second;
   logic        irq_quiet;

   function automatic logic is_mapped(input logic [7:0] a);
      return a == OFF_DATA || a == OFF_ERROR || a == OFF_SEC_CNT || a == OFF_SEC_NUM ||
             a == OFF_CYL_LO || a == OFF_CYL_HI || a == OFF_DRV_HEAD ||
             a == OFF_CMD_STAT || a == OFF_DEV_CTRL || a == OFF_CONFIG;
   endfunction : is_mapped

   function automatic logic is_pwr_query(input logic [7:0] op);
      return op == OP_PWR_QUERY_A || op == OP_PWR_QUERY_B;
   endfunction : is_pwr_query

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode and status view

   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign pready = 1'b1;
   assign pslverr = access && !is_mapped(paddr);

   // Access-phase read strobes: data reads step the identify transfer, status reads clear the interrupt
   assign data_rd = access && !pwrite && paddr == OFF_DATA;
   assign stat_rd = access && !pwrite && paddr == OFF_CMD_STAT;

   always_comb
   begin
      status          = 8'h00;
      status[ST_BUSY] = s_q.busy;
      status[ST_RDY]  = !s_q.busy && !s_q.srst;
      status[ST_DWF]  = s_q.dwf;
      status[ST_DSC]  = !s_q.busy;
      status[ST_DRQ]  = s_q.drq;
      status[ST_ERR]  = s_q.err;
   end

   assign diag_start = s_q.st == S_EXEC && s_q.cnt == 8'h00 && s_q.cur_cmd == OP_DIAG;

   assign drv_match   = s_q.drv_head[DH_DRV] == s_q.second;
   // Only a disk-emulation primary folds the other drive's result into its code
   assign diag_second = s_q.emu && !s_q.second;
   // A disk-emulation secondary finishes its self test without an interrupt
   assign irq_quiet   = s_q.cur_cmd == OP_DIAG && s_q.emu && s_q.second;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      s_d             = s_q;
      s_d.sfail_sync  = {s_q.sfail_sync[0], second_fail_pin};
      s_d.mfault_sync = {s_q.mfault_sync[0], media_fault_pin};

      // Read data is captured in the setup phase and held through access
      if (setup && !pwrite)
      begin
         s_d.prdata = 32'h0000_0000;
         unique case (paddr)
            OFF_DATA:     s_d.prdata = s_q.drq ? {16'h0000, rom_q} : 32'h0000_0000;
            OFF_ERROR:    s_d.prdata[7:0] = s_q.err_reg;
            OFF_SEC_CNT:  s_d.prdata[7:0] = s_q.sec_cnt;
            OFF_SEC_NUM:  s_d.prdata[7:0] = s_q.sec_num;
            OFF_CYL_LO:   s_d.prdata[7:0] = s_q.cyl_lo;
            OFF_CYL_HI:   s_d.prdata[7:0] = s_q.cyl_hi;
            OFF_DRV_HEAD: s_d.prdata[7:0] = s_q.drv_head;
            OFF_CMD_STAT: s_d.prdata[7:0] = status;
            OFF_DEV_CTRL: s_d.prdata[7:0] = {5'h00, s_q.srst, s_q.nien, 1'b0};
            OFF_CONFIG:   s_d.prdata[7:0] = {1'b0, s_q.self_code, s_q.pwr, s_q.second, s_q.emu};
            default:      s_d.prdata = 32'h0000_0000;
         endcase
      end

      // Sequencer
      unique case (s_q.st)
         S_IDLE: ;
         S_EXEC:
         begin
            if (s_q.cnt != 8'h00)
               s_d.cnt = s_q.cnt - 8'h01;
            else if (is_pwr_query(s_q.cur_cmd))
            begin
               s_d.sec_cnt = (s_q.pwr == PWR_IDLE) ? PWR_CNT_IDLE
                                                   : PWR_CNT_STBY;
               s_d.busy    = 1'b0;
               s_d.st      = S_FINISH;
            end
            else if (s_q.cur_cmd == OP_DIAG)
               s_d.st = S_WAIT_DIAG;
            else if (s_q.cur_cmd == OP_ERASE)
            begin
               s_d.dwf  = s_q.mfault_sync[1];
               s_d.err  = s_q.mfault_sync[1];
               s_d.busy = 1'b0;
               s_d.st   = S_FINISH;
            end
            else if (s_q.cur_cmd == OP_IDENTIFY)
            begin
               s_d.busy = 1'b0;
               s_d.drq  = 1'b1;
               s_d.widx = 9'h000;
               s_d.st   = S_FINISH;
            end
            else
            begin
               s_d.err     = 1'b1;
               s_d.err_reg = ERR_ABORT;
               s_d.busy    = 1'b0;
               s_d.st      = S_FINISH;
            end
         end
         S_WAIT_DIAG:
         begin
            if (diag_done)
            begin
               s_d.err_reg = diag_code;
               s_d.busy    = 1'b0;
               s_d.st      = S_FINISH;
            end
         end
         S_FINISH:
         begin
            // Secondary stays quiet after an emulation-mode self test
            if (!irq_quiet)
               s_d.irq = 1'b1;
            s_d.st = s_q.drq ? S_XFER : S_IDLE;
         end
         S_XFER:
         begin
            if (data_rd)
            begin
               s_d.widx = s_q.widx + 9'h001;
               if (s_q.widx == 9'(IDENT_WORDS - 1))
               begin
                  s_d.drq = 1'b0;
                  s_d.st  = S_IDLE;
               end
            end
         end
      endcase

      // Register writes on the access phase
      if (access && pwrite)
      begin
         if (paddr == OFF_DEV_CTRL)
         begin
            s_d.nien = pwdata[DC_NIEN];
            s_d.srst = pwdata[DC_SRST];
         end
         else if (!s_q.busy && !s_q.drq)
         begin
            unique case (paddr)
               OFF_SEC_CNT:  s_d.sec_cnt  = pwdata[7:0];
               OFF_SEC_NUM:  s_d.sec_num  = pwdata[7:0];
               OFF_CYL_LO:   s_d.cyl_lo   = pwdata[7:0];
               OFF_CYL_HI:   s_d.cyl_hi   = pwdata[7:0];
               OFF_DRV_HEAD: s_d.drv_head = pwdata[7:0];
               OFF_CONFIG:
               begin
                  s_d.emu       = pwdata[CF_EMU];
                  s_d.second    = pwdata[CF_SECOND];
                  s_d.pwr       = pwdata[CF_PWR_LO +: 2];
                  s_d.self_code = pwdata[CF_CODE_LO +: 3];
               end
               OFF_CMD_STAT:
               begin
                  // Opcodes arriving while busy are dropped
                  if (!s_q.srst &&
                      (drv_match ||
                       (pwdata[7:0] == OP_DIAG && s_q.emu)))
                  begin
                     s_d.cur_cmd = pwdata[7:0];
                     s_d.busy    = 1'b1;
                     s_d.err     = 1'b0;
                     s_d.dwf     = 1'b0;
                     s_d.irq     = 1'b0;
                     s_d.cnt     = EXEC_CYC;
                     s_d.st      = S_EXEC;
                  end
               end
               default: ;
            endcase
         end
      end

      // Reading status acknowledges the interrupt request
      if (stat_rd && s_q.st != S_FINISH)
         s_d.irq = 1'b0;

      // Soft reset holds the card busy and idle
      if (s_q.srst)
      begin
         s_d.st      = S_IDLE;
         s_d.busy    = 1'b1;
         s_d.drq     = 1'b0;
         s_d.err     = 1'b0;
         s_d.dwf     = 1'b0;
         s_d.irq     = 1'b0;
         s_d.err_reg = DIAG_OK;
         if (!s_d.srst)
            s_d.busy = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q           <= '0;
         s_q.st        <= S_IDLE;
         s_q.err_reg   <= DIAG_OK;
         s_q.sec_cnt   <= SEC_CNT_RST;
         s_q.sec_num   <= SEC_NUM_RST;
         s_q.self_code <= SELF_CODE_RST;
      end
      else
         s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sub-blocks

   sccs_ident_rom u_rom
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .addr     (s_d.widx[7:0]),
      .emu_mode (s_q.emu),
      .q        (rom_q)
   );

   sccs_diag u_diag
   (
      .pclk          (pclk),
      .presetn       (presetn),
      .start         (diag_start),
      .self_code     (s_q.self_code),
      .report_second (diag_second),
      .second_fail   (s_q.sfail_sync[1]),
      .done          (diag_done),
      .code          (diag_code)
   );

   assign prdata               = s_q.prdata;
   assign intrq                = s_q.irq && !s_q.nien;
   assign cmd_in_progress_flag = s_q.busy;

endmodule : sccs_cmd
`default_nettype wire

// ===== verification/sccs_peer.sv
/*
 * Far side model: other drive's self test result and media fault source.
 * Assumes the bench sets the wanted levels; pins follow one edge later.
 */
`timescale 1ns/100ps
`default_nettype none
module sccs_peer
(
   input  wire logic pclk,
   input  wire logic sec_bad,
   input  wire logic media_bad,
   output logic      second_fail_pin,
   output logic      media_fault_pin
);
   always_ff @(posedge pclk)
   begin
      second_fail_pin <= sec_bad;
      media_fault_pin <= media_bad;
   end
endmodule : sccs_peer
`default_nettype wire

// ===== verification/sccs_cmd_sva.sv
/*
 * Port checker of the command block.
 * Assumes it is bound to sccs_cmd and shares its single clock.
 */
`timescale 1ns/100ps
`default_nettype none
module sccs_cmd_sva
   import sccs_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        second_fail_pin,
   input wire logic        media_fault_pin,
   input wire logic        intrq,
   input wire logic        cmd_in_progress_flag
);
   typedef struct packed {logic nien; logic srst; logic emu; logic sec; logic dsel;} sccs_chk_t;
   sccs_chk_t h_q;
   sccs_chk_t h_d;
   wire logic acc = psel && penable;
   wire logic wr_ok = acc && pwrite && !cmd_in_progress_flag;
   wire logic wr_ctl = acc && pwrite && (paddr == OFF_CMD_STAT || paddr == OFF_DEV_CTRL);

   // Shadow of the settings that decide acceptance and masking
   always_comb
   begin
      h_d = h_q;
      if (acc && pwrite && paddr == OFF_DEV_CTRL)
         {h_d.srst, h_d.nien} = {pwdata[DC_SRST], pwdata[DC_NIEN]};
      if (wr_ok && paddr == OFF_CONFIG)
         {h_d.sec, h_d.emu} = pwdata[1:0];
      if (wr_ok && paddr == OFF_DRV_HEAD)
         h_d.dsel = pwdata[DH_DRV];
   end
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         h_q <= '0;
      else
         h_q <= h_d;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////
   sequence cmd_ok_s;
      wr_ok && paddr == OFF_CMD_STAT && (h_q.dsel == h_q.sec || (h_q.emu && pwdata[7:0] == OP_DIAG));
   endsequence
   sequence busy_done_s;
      $fell(cmd_in_progress_flag) && !h_q.nien && !(h_q.emu && h_q.sec) && !$past(h_q.srst);
   endsequence

   busy_set_a: assert property (cmd_ok_s |-> ##[1:8] cmd_in_progress_flag)
      else $error("busy late after command");
   busy_cause_a: assert property ($rose(cmd_in_progress_flag) && !h_q.srst |-> $past(wr_ctl))
      else $error("busy rose without a command");
   srst_busy_a: assert property (h_q.srst && $past(h_q.srst) |-> cmd_in_progress_flag)
      else $error("busy clear during soft reset");
   busy_bound_a: assert property ($rose(cmd_in_progress_flag) && !h_q.srst |-> ##[1:64] !cmd_in_progress_flag)
      else $error("busy never cleared");
   irq_order_a: assert property ($rose(intrq) |-> !cmd_in_progress_flag && !$past(cmd_in_progress_flag))
      else $error("interrupt before busy cleared");
   irq_raise_a: assert property (busy_done_s |-> ##1 intrq)
      else $error("no interrupt after completion");
   irq_mask_a: assert property (h_q.nien |-> !intrq)
      else $error("interrupt while disabled");
   bus_resp_a: assert property (acc |-> pready && pslverr == (paddr > OFF_CONFIG || paddr[1:0] != 2'h0))
      else $error("bad bus response");
   stat_busy_a: assert property (acc && !pwrite && paddr == OFF_CMD_STAT |-> prdata[ST_BUSY] == $past(cmd_in_progress_flag))
      else $error("status busy bit wrong");
endmodule : sccs_cmd_sva

bind sccs_cmd sccs_cmd_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .second_fail_pin(second_fail_pin), .media_fault_pin(media_fault_pin), .intrq(intrq),
   .cmd_in_progress_flag(cmd_in_progress_flag));
`default_nettype wire

// ===== verification/sccs_cmd_bench.sv
/*
 * Self-checking bench of the command block: APB host tasks and command scenarios.
 * Assumes the far side model sccs_peer and the bound checker.
 */
`timescale 1ns/100ps
`default_nettype none
module sccs_cmd_bench
   import sccs_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, sec_bad, media_bad;
   logic        pready, pslverr, intrq, busy, sfp, mfp;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   int          n_fail, cmp_count, cyc;
   logic [31:0] dcfg [5] = '{32'h30, 32'h31, 32'h31, 32'h50, 32'h23};
   logic [31:0] dexp [5] = '{32'h03, 32'h83, 32'h03, 32'h03, 32'h02};

   sccs_cmd dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .second_fail_pin(sfp), .media_fault_pin(mfp), .intrq(intrq), .cmd_in_progress_flag(busy));
   sccs_peer peer (.pclk(pclk), .sec_bad(sec_bad), .media_bad(media_bad), .second_fail_pin(sfp),
      .media_fault_pin(mfp));

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////
   task summarize;
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; read data lands in d
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Issue an opcode, wait for completion, check the interrupt, read status into d
   task cmd(input logic [7:0] op, input logic irq);
      apb(1'b1, OFF_CMD_STAT, {24'h0, op});
      @(negedge pclk);
      while (busy !== 1'b0) @(negedge pclk);
      @(negedge pclk);
      chk({31'h0, intrq}, {31'h0, irq});
      apb(1'b0, OFF_CMD_STAT, 32'h0);
   endtask : cmd

   ////////////////////////////////////////////////////////////////
   initial
   begin
      {presetn, psel, penable, pwrite, sec_bad, media_bad} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_fail = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFF_ERROR, 32'h0);
      chk(d, 32'h01);
      apb(1'b0, 8'h28, 32'h0);
      chk(d, 32'h0);
      for (int p = 0; p < 4; p++)
      begin
         apb(1'b1, OFF_CONFIG, p[1] ? 32'h4 : 32'h0);
         apb(1'b1, OFF_DEV_CTRL, p == 3 ? 32'h2 : 32'h0);
         cmd(p[0] ? OP_PWR_QUERY_B : OP_PWR_QUERY_A, p != 3);
         apb(1'b0, OFF_SEC_CNT, 32'h0);
         chk(d, p[1] ? 32'h00 : 32'hFF);
      end
      apb(1'b1, OFF_DEV_CTRL, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         sec_bad <= (i < 2 || i == 4);
         apb(1'b1, OFF_CONFIG, dcfg[i]);
         apb(1'b1, OFF_DRV_HEAD, (i == 2 || i == 3) ? 32'h10 : 32'h0);
         cmd(OP_DIAG, i < 3);
         apb(1'b0, OFF_ERROR, 32'h0);
         chk(d, dexp[i]);
      end
      // Soft reset: busy held, opcodes dropped, error register preset
      apb(1'b1, OFF_DEV_CTRL, 32'h4);
      apb(1'b1, OFF_CMD_STAT, {24'h0, OP_PWR_QUERY_A});
      apb(1'b0, OFF_CMD_STAT, 32'h0);
      chk(d & 32'hC0, 32'h80);
      apb(1'b1, OFF_DEV_CTRL, 32'h0);
      apb(1'b0, OFF_ERROR, 32'h0);
      chk(d, {24'h0, DIAG_OK});
      apb(1'b0, OFF_CMD_STAT, 32'h0);
      chk(d, 32'h50);
      apb(1'b1, OFF_CONFIG, 32'h0);
      apb(1'b1, OFF_DRV_HEAD, 32'h40);
      for (int f = 0; f < 2; f++)
      begin
         media_bad <= f[0];
         for (int k = 0; k < 4; k++)
            apb(1'b1, OFF_SEC_CNT + 8'(4 * k), 32'h10 + k);
         cmd(OP_ERASE, 1'b1);
         chk(d & 32'hA9, f ? 32'h21 : 32'h00);
      end
      // Unsupported opcode aborts with an error
      cmd(8'h00, 1'b1);
      chk(d & 32'h01, 32'h01);
      apb(1'b0, OFF_ERROR, 32'h0);
      chk(d, {24'h0, ERR_ABORT});
      for (int e = 0; e < 2; e++)
      begin
         apb(1'b1, OFF_CONFIG, e);
         cmd(OP_IDENTIFY, 1'b1);
         chk(d & 32'h89, 32'h08);
         for (int w = 0; w < 256; w++)
         begin
            apb(1'b0, OFF_DATA, 32'h0);
            case (w)
               0: chk(d, e ? 32'h40 : 32'h80);
               1: chk(d, 32'h03D0);
               2: chk(d, 32'h0);
               3: chk(d, 32'h10);
               6: chk(d, 32'h20);
               7: chk(d, 32'h7);
               8: chk(d, 32'hA000);
               10: chk(d, 32'h2020);
               19: chk(d, 32'h3031);
               23: chk(d, 32'h312E);
               27: chk(d, 32'h464C);
               46: chk(d, 32'h2020);
               47: chk(d & 32'hFF, 32'h1);
               49: chk(d & 32'h2300, 32'h0300);
               51: chk(d & 32'hFF00, 32'h0200);
               53: chk(d & 32'h3, 32'h3);
               default: ;
            endcase
         end
         apb(1'b0, OFF_CMD_STAT, 32'h0);
         chk(d & 32'h08, 32'h0);
      end
      summarize();
   end
endmodule : sccs_cmd_bench
`default_nettype wire
